/* File: common/mtg_pkg.sv */
package mtg_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_FIXED_DATA = 8'h08;
	localparam logic [7:0] OFS_FIXED_ADDR = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_ERR_ADDR = 8'h14;
	localparam logic [7:0] OFS_ERR_INFO = 8'h18;
	localparam logic [7:0] OFS_ERR_EXP = 8'h1c;
	localparam logic [7:0] OFS_ERR_READ = 8'h20;
	localparam logic [2:0] OFS_REPEAT_PAGE = 3'h2;
	// ---------------------------------------------------------------
	// fields and reset values
	// ---------------------------------------------------------------
	localparam int CB_RUN = 0;
	localparam int CB_MOD = 1;
	localparam int CB_CLR = 2;
	localparam int MF_AM = 4;
	localparam int MF_IM = 8;
	localparam int MF_OP = 12;
	localparam int MF_BL = 16;
	localparam logic [31:0] MODE_MASK = 32'h003f_7f7f;
	localparam logic [31:0] MODE_RST = 32'h000f_0222;
	localparam logic [31:0] ALFSR_RST = 32'h0000_0001;
	localparam logic [31:0] SEED_ALT = 32'h0000_0001;
	localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
	localparam int ES_BL = 32;
	localparam int ES_FLAG = 40;
	localparam int ES_EXP = 64;
	localparam int ES_RD = 96;
	// ---------------------------------------------------------------
	// codes
	// ---------------------------------------------------------------
	localparam logic [2:0] OP_WR = 3'h0;
	localparam logic [2:0] OP_RD = 3'h1;
	localparam logic [3:0] DM_FIXED = 4'h1;
	localparam logic [3:0] DM_ADDR = 4'h2;
	localparam logic [3:0] DM_HAMMER = 4'h3;
	localparam logic [3:0] DM_REPEAT8 = 4'h4;
	localparam logic [3:0] DM_WALK1 = 4'h5;
	localparam logic [3:0] DM_WALK0 = 4'h6;
	localparam logic [3:0] DM_PRBS = 4'h7;
	localparam logic [3:0] DM_SLOWHAM = 4'h9;
	localparam logic [3:0] DM_TRAIN = 4'hf;
	localparam logic [2:0] AM_FIXED = 3'h1;
	localparam logic [2:0] AM_LFSR = 3'h2;
	localparam logic [2:0] AM_SEQ = 3'h3;
	localparam logic [3:0] IM_FIXED = 4'h1;
	localparam logic [3:0] IM_RAND = 4'h2;
	localparam logic [3:0] IM_WR0 = 4'he;
	localparam logic [3:0] IM_RD0 = 4'hf;
	localparam logic [7:0][7:0] TRAIN_SEQ = {8'h66, 8'h99, 8'haa, 8'h55,
		8'h55, 8'haa, 8'h00, 8'hff};
	typedef enum {PS_HAMMER, PS_WALKING, PS_PRBS, PS_ALL} mtg_pset_t;
	typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_WR, ST_RD} mtg_fsm_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [5:0] burst_len;
		logic [2:0] opcode;
	} mtg_cmd_t;
	typedef struct packed {
		mtg_fsm_t fsm;
		mtg_cmd_t cmd;
		logic [3:0] dmode;
		logic cmd_push;
		logic wr_push;
		logic [31:0] wr_data;
		logic [5:0] beat;
		logic [31:0] alfsr;
		logic [31:0] seq_addr;
		logic [31:0] dlfsr;
		logic error;
		logic cmp_err;
		logic [127:0] status;
		logic [1:0] ctrl;
		logic clr;
		logic [31:0] mode;
		logic [31:0] fixed_data;
		logic [31:0] fixed_addr;
		logic [7:0][31:0] rep;
		logic aw_got;
		logic w_got;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic rvalid;
		logic [31:0] rdata;
	} mtg_state_t;
endpackage

/* File: verilog/mtg_top.sv */
`timescale 1ns/1ps
// Functional notes
// - error clear drops the latched error flag.
// - each transaction shows its 32-bit start address on the command bus.
// - burst length output is words minus one, 0..63 for 1..64.
// - command push is active high, the command queue write strobe.
// - while command full, push, address and opcode hold steady.
// - opcode is 000 for write, 001 for read.
// - write push, active high, marks valid write words.
// - runtime selectors affect traffic only while override enable is set.
// - data mode 1 sends the fixed word; mode 0 is reserved.
// - data mode 2 sends each beat's address (start address plus four per beat) as data.
// - mode 3 hammers ones/zeros per beat, quiet lane inverted, set-gated.
// - mode 4 cycles eight user words.
// - mode 5 walks a one, start lane from address, set-gated.
// - mode 6 walks a zero, start lane from address.
// - mode 7 sends 32-stage lfsr data seeded by start address.
// - mode 9 sends a slow hammer pattern.
// - mode f sends training bytes, reads only at address zero.
// - compare error asserts when expected and read words differ.
// - on an error with none latched, capture address, length, queue flags, expected, read.
// - address mode 1 fixed, 2 lfsr default, 3 sequential by width.
// - opcode mode 1 fixed, 2 random, e writes at 0, f reads at 0.
module mtg_top #(
	parameter mtg_pkg::mtg_pset_t PATTERN_SET = mtg_pkg::PS_ALL,
	parameter logic [4:0] QUIET_LANE_SEL = 5'h0
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// controller command queue
	input wire logic ctrl_ready,
	output logic [31:0] cmd_addr,
	output logic [5:0] cmd_burst_len,
	output logic [2:0] cmd_opcode,
	output logic cmd_push,
	input wire logic cmd_full,
	// controller data queues
	output logic [31:0] wr_data,
	output logic wr_push,
	input wire logic wr_full,
	input wire logic [31:0] rd_data,
	input wire logic rd_empty,
	output logic rd_pop,
	// check results
	output logic cmp_error,
	output logic error,
	output logic [127:0] error_status
);
	mtg_pkg::mtg_state_t s, n;
	logic [31:0] exp_word;
	logic mismatch;

	function automatic logic [31:0] lfsr_step(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// zero would lock the lfsr
	function automatic logic [31:0] seed(input logic [31:0] a);
		return (a == 32'h0) ? mtg_pkg::SEED_ALT : a;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] st);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] pat_word(input logic [3:0] m,
		input logic [31:0] a, input logic [5:0] b, input logic [31:0] lf,
		input logic [31:0] fx, input logic [7:0][31:0] rep);
		logic [31:0] w;
		logic [4:0] pos;
		pos = a[6:2] + b[4:0];
		w = a + {24'h0, b, 2'h0};
		case (m)
			mtg_pkg::DM_FIXED: w = fx;
			mtg_pkg::DM_HAMMER: begin
				w = {32{~b[0]}};
				w[QUIET_LANE_SEL] = b[0];
			end
			mtg_pkg::DM_REPEAT8: w = rep[b[2:0]];
			mtg_pkg::DM_WALK1: w = 32'h0000_0001 << pos;
			mtg_pkg::DM_WALK0: w = ~(32'h0000_0001 << pos);
			mtg_pkg::DM_PRBS: w = lf;
			mtg_pkg::DM_SLOWHAM: w = {32{~b[3]}};
			mtg_pkg::DM_TRAIN: w = {4{mtg_pkg::TRAIN_SEQ[b[2:0]]}};
			default: w = a + {24'h0, b, 2'h0};
		endcase
		return w;
	endfunction

	function automatic logic [31:0] rd_mux(input mtg_pkg::mtg_state_t t,
		input logic [7:0] a, input logic rdy);
		logic [31:0] r;
		r = 32'h0;
		if (a[7:5] == mtg_pkg::OFS_REPEAT_PAGE && a[1:0] == 2'h0) begin
			r = t.rep[a[4:2]];
		end
		case (a)
			mtg_pkg::OFS_CTRL: r = {30'h0, t.ctrl};
			mtg_pkg::OFS_MODE: r = t.mode;
			mtg_pkg::OFS_FIXED_DATA: r = t.fixed_data;
			mtg_pkg::OFS_FIXED_ADDR: r = t.fixed_addr;
			mtg_pkg::OFS_STATUS: begin
				r = {29'h0, rdy, t.fsm != mtg_pkg::ST_IDLE, t.error};
			end
			mtg_pkg::OFS_ERR_ADDR: r = t.status[31:0];
			mtg_pkg::OFS_ERR_INFO: r = t.status[63:32];
			mtg_pkg::OFS_ERR_EXP: r = t.status[95:64];
			mtg_pkg::OFS_ERR_READ: r = t.status[127:96];
			default: r = r;
		endcase
		return r;
	endfunction

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign s_axi_awready = !s.aw_got && !s.bvalid;
	assign s_axi_wready = !s.w_got && !s.bvalid;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_bresp = 2'h0;
	assign s_axi_rresp = 2'h0;
	assign cmd_addr = s.cmd.addr;
	assign cmd_burst_len = s.cmd.burst_len;
	assign cmd_opcode = s.cmd.opcode;
	assign cmd_push = s.cmd_push && ctrl_ready;
	assign wr_push = s.wr_push && ctrl_ready;
	assign wr_data = s.wr_data;
	assign rd_pop = (s.fsm == mtg_pkg::ST_RD) && !rd_empty;
	assign cmp_error = s.cmp_err;
	assign error = s.error;
	assign error_status = s.status;
	assign exp_word = pat_word(s.dmode, s.cmd.addr, s.beat, s.dlfsr,
		s.fixed_data, s.rep);
	assign mismatch = rd_pop && (rd_data != exp_word);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [3:0] dm;
		logic [2:0] am;
		logic [3:0] im;
		logic ok;
		logic [31:0] a;
		logic [2:0] op;
		ok = 1'b0;
		a = 32'h0;
		op = 3'h0;
		n = s;
		n.cmp_err = 1'b0;
		n.clr = 1'b0;
		// register writes, address and data in either order
		if (s_axi_awvalid && s_axi_awready) begin
			n.aw_got = 1'b1;
			n.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			n.w_got = 1'b1;
			n.w_data = s_axi_wdata;
			n.w_strb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s.aw_got && s.w_got) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			if (s.aw_addr[7:5] == mtg_pkg::OFS_REPEAT_PAGE &&
				s.aw_addr[1:0] == 2'h0) begin
				n.rep[s.aw_addr[4:2]] = merge(s.rep[s.aw_addr[4:2]],
					s.w_data, s.w_strb);
			end
			case (s.aw_addr)
				mtg_pkg::OFS_CTRL: begin
					n.ctrl = 2'(merge({30'h0, s.ctrl}, s.w_data,
						s.w_strb));
					n.clr = s.w_strb[0] && s.w_data[mtg_pkg::CB_CLR];
				end
				mtg_pkg::OFS_MODE: begin
					n.mode = merge(s.mode, s.w_data, s.w_strb) &
						mtg_pkg::MODE_MASK;
				end
				mtg_pkg::OFS_FIXED_DATA: begin
					n.fixed_data = merge(s.fixed_data, s.w_data, s.w_strb);
				end
				mtg_pkg::OFS_FIXED_ADDR: begin
					n.fixed_addr = merge(s.fixed_addr, s.w_data, s.w_strb);
				end
				default: n.ctrl = n.ctrl;
			endcase
		end
		if (s_axi_arvalid && s_axi_arready) begin
			n.rvalid = 1'b1;
			n.rdata = rd_mux(s, s_axi_araddr, ctrl_ready);
		end
		if (s.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		// selectors fall back to defaults unless override is on
		dm = mtg_pkg::DM_ADDR;
		am = mtg_pkg::AM_LFSR;
		im = mtg_pkg::IM_RAND;
		if (s.ctrl[mtg_pkg::CB_MOD]) begin
			dm = s.mode[3:0];
			am = s.mode[mtg_pkg::MF_AM +: 3];
			im = s.mode[mtg_pkg::MF_IM +: 4];
		end
		// patterns not built into this instance run as address data
		case (dm)
			mtg_pkg::DM_FIXED, mtg_pkg::DM_ADDR, mtg_pkg::DM_REPEAT8,
			mtg_pkg::DM_SLOWHAM, mtg_pkg::DM_TRAIN: ok = 1'b1;
			mtg_pkg::DM_HAMMER: begin
				ok = PATTERN_SET == mtg_pkg::PS_HAMMER ||
					PATTERN_SET == mtg_pkg::PS_ALL;
			end
			mtg_pkg::DM_WALK1, mtg_pkg::DM_WALK0: begin
				ok = PATTERN_SET == mtg_pkg::PS_WALKING ||
					PATTERN_SET == mtg_pkg::PS_ALL;
			end
			mtg_pkg::DM_PRBS: ok = PATTERN_SET == mtg_pkg::PS_ALL;
			default: ok = 1'b0;
		endcase
		case (am)
			mtg_pkg::AM_FIXED: a = s.fixed_addr;
			mtg_pkg::AM_SEQ: a = s.seq_addr;
			default: a = s.alfsr;
		endcase
		case (im)
			mtg_pkg::IM_FIXED: op = s.mode[mtg_pkg::MF_OP +: 3];
			mtg_pkg::IM_WR0: op = mtg_pkg::OP_WR;
			mtg_pkg::IM_RD0: op = mtg_pkg::OP_RD;
			default: op = {2'h0, s.alfsr[7]};
		endcase
		if (im == mtg_pkg::IM_WR0 || im == mtg_pkg::IM_RD0) begin
			a = 32'h0;
		end
		if (ok && dm == mtg_pkg::DM_TRAIN) begin
			op = mtg_pkg::OP_RD;
			a = 32'h0;
		end
		if (s.clr) begin
			n.error = 1'b0;
		end
		unique case (s.fsm)
			mtg_pkg::ST_IDLE: begin
				if (s.ctrl[mtg_pkg::CB_RUN] && ctrl_ready) begin
					n.cmd.addr = a;
					n.cmd.burst_len = s.mode[mtg_pkg::MF_BL +: 6];
					n.cmd.opcode = op;
					n.dmode = ok ? dm : mtg_pkg::DM_ADDR;
					n.alfsr = lfsr_step(s.alfsr);
					n.seq_addr = s.seq_addr + mtg_pkg::ADDR_STEP;
					n.cmd_push = 1'b1;
					n.fsm = mtg_pkg::ST_CMD;
				end
			end
			mtg_pkg::ST_CMD: begin
				if (cmd_push && !cmd_full) begin
					n.cmd_push = 1'b0;
					n.beat = 6'h0;
					n.dlfsr = seed(s.cmd.addr);
					n.fsm = mtg_pkg::ST_RD;
					if (s.cmd.opcode == mtg_pkg::OP_WR) begin
						n.fsm = mtg_pkg::ST_WR;
						n.wr_push = 1'b1;
						n.wr_data = pat_word(s.dmode, s.cmd.addr, 6'h0,
							seed(s.cmd.addr), s.fixed_data, s.rep);
					end
				end
			end
			mtg_pkg::ST_WR: begin
				if (wr_push && !wr_full) begin
					if (s.beat == s.cmd.burst_len) begin
						n.wr_push = 1'b0;
						n.fsm = mtg_pkg::ST_IDLE;
					end else begin
						n.beat = s.beat + 6'h1;
						n.dlfsr = lfsr_step(s.dlfsr);
						n.wr_data = pat_word(s.dmode, s.cmd.addr,
							s.beat + 6'h1, lfsr_step(s.dlfsr),
							s.fixed_data, s.rep);
					end
				end
			end
			mtg_pkg::ST_RD: begin
				if (rd_pop) begin
					n.beat = s.beat + 6'h1;
					n.dlfsr = lfsr_step(s.dlfsr);
					if (s.beat == s.cmd.burst_len) begin
						n.fsm = mtg_pkg::ST_IDLE;
					end
				end
			end
		endcase
		if (mismatch) begin
			n.cmp_err = 1'b1;
			n.error = 1'b1;
			if (!s.error) begin
				n.status = {rd_data, exp_word, 21'h0, rd_empty, wr_full,
					cmd_full, 2'h0, s.cmd.burst_len, s.cmd.addr};
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.alfsr <= mtg_pkg::ALFSR_RST;
			s.mode <= mtg_pkg::MODE_RST;
		end else begin
			s <= n;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_cmd_ready;
		@(posedge aclk) disable iff (!aresetn)
		!ctrl_ready |-> !cmd_push;
	endproperty
	a_cmd_ready: assert property (p_cmd_ready)
		else $error("command push while controller not ready");
	property p_wr_ready;
		@(posedge aclk) disable iff (!aresetn)
		!ctrl_ready |-> !wr_push;
	endproperty
	a_wr_ready: assert property (p_wr_ready)
		else $error("write push while controller not ready");
	property p_cmd_hold;
		@(posedge aclk) disable iff (!aresetn)
		cmd_push && cmd_full && ctrl_ready |=> cmd_push &&
			$stable(cmd_addr) && $stable(cmd_opcode);
	endproperty
	a_cmd_hold: assert property (p_cmd_hold)
		else $error("command changed while queue full");
	property p_wr_hold;
		@(posedge aclk) disable iff (!aresetn)
		wr_push && wr_full && ctrl_ready |=> wr_push && $stable(wr_data);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write word changed while queue full");
	property p_opcode;
		@(posedge aclk) disable iff (!aresetn)
		cmd_push |-> cmd_opcode == mtg_pkg::OP_WR ||
			cmd_opcode == mtg_pkg::OP_RD;
	endproperty
	a_opcode: assert property (p_opcode)
		else $error("illegal opcode pushed");
	property p_clear;
		@(posedge aclk) disable iff (!aresetn)
		s.clr && !mismatch |=> !error;
	endproperty
	a_clear: assert property (p_clear)
		else $error("error flag survived clear");
	property p_cmp;
		@(posedge aclk) disable iff (!aresetn)
		mismatch |=> cmp_error && error;
	endproperty
	a_cmp: assert property (p_cmp)
		else $error("mismatch not flagged");
	property p_capture;
		@(posedge aclk) disable iff (!aresetn)
		mismatch && !error |=> error_status[31:0] == cmd_addr &&
			error_status[37:32] == cmd_burst_len;
	endproperty
	a_capture: assert property (p_capture)
		else $error("error capture wrong");
	property p_train;
		@(posedge aclk) disable iff (!aresetn)
		cmd_push && s.dmode == mtg_pkg::DM_TRAIN |->
			cmd_opcode == mtg_pkg::OP_RD && cmd_addr == 32'h0;
	endproperty
	a_train: assert property (p_train)
		else $error("training mode issued non-read");
endmodule

/* File: sim/mtg_mem_model.sv */
`timescale 1ns/1ps
module mtg_mem_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// scenario controls
	input wire logic ready_en,
	input wire logic stall,
	input wire logic corrupt,
	// generator side
	output logic ctrl_ready,
	input wire logic [31:0] cmd_addr,
	input wire logic [5:0] cmd_burst_len,
	input wire logic [2:0] cmd_opcode,
	input wire logic cmd_push,
	output logic cmd_full,
	input wire logic [31:0] wr_data,
	input wire logic wr_push,
	output logic wr_full,
	output logic [31:0] rd_data,
	output logic rd_empty,
	input wire logic rd_pop
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] rq [$];
	logic [31:0] wa;
	logic [31:0] a;
	logic [1:0] cnt;
	initial rd_empty = 1'b1;
	initial rd_data = 32'h0;
	assign ctrl_ready = ready_en;
	// queues refuse three cycles in four while stalling
	assign cmd_full = stall && (cnt != 2'h0);
	assign wr_full = stall && (cnt != 2'h1);
	always @(posedge aclk) begin
		cnt <= cnt + 2'h1;
		if (!aresetn) begin
			rq.delete();
			cnt <= 2'h0;
		end
		if (cmd_push && !cmd_full && cmd_opcode == mtg_pkg::OP_WR)
			wa = cmd_addr;
		if (cmd_push && !cmd_full && cmd_opcode == mtg_pkg::OP_RD)
			for (int i = 0; i <= cmd_burst_len; i++) begin
				a = cmd_addr + 32'h4 * i;
				a = mem.exists(a) ? mem[a] : ~a;
				// only the first word of a burst is spoiled
				rq.push_back(a ^ {31'h0, corrupt && i == 0});
			end
		if (wr_push && !wr_full) begin
			mem[wa] = wr_data;
			wa = wa + 32'h4;
		end
		if (rd_pop && !rd_empty) begin
			// a consumed word does not linger on the bus
			rd_data <= ~rq[0];
			rq.pop_front();
		end
		rd_empty <= (rq.size() == 0);
		if (rq.size() != 0)
			rd_data <= rq[0];
	end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	localparam logic [31:0] FA = 32'h0000_0134;
	localparam logic [31:0] FD = 32'h5a3c_96e1;
	localparam logic [4:0] QUIET = 5'h3;
	// data modes 1 to 7 and 9
	localparam logic [7:0][3:0] DMS = 32'h9765_4321;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h0;
	logic [7:0] s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, cmp_error, error;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, cmd_addr, wr_data, rd_data;
	logic ctrl_ready, cmd_push, cmd_full, wr_push, wr_full;
	logic rd_empty, rd_pop;
	logic [5:0] cmd_burst_len;
	logic [2:0] cmd_opcode;
	logic [127:0] error_status;
	logic ready_en = 1'b0;
	logic stall = 1'b0;
	logic corrupt = 1'b0;
	logic cmd_hold = 1'b0;
	logic wr_hold = 1'b0;
	int err_count = 0;
	int n_compared = 0;
	int cerr_n = 0;
	mtg_pkg::mtg_cmd_t cq [$];
	mtg_pkg::mtg_cmd_t cprev;
	logic [31:0] wq [$];
	logic [31:0] wprev;
	always #25 aclk = ~aclk;
	mtg_top #(.QUIET_LANE_SEL(QUIET)) dut_u (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .ctrl_ready, .cmd_addr, .cmd_burst_len, .cmd_opcode,
		.cmd_push, .cmd_full, .wr_data, .wr_push, .wr_full, .rd_data,
		.rd_empty, .rd_pop, .cmp_error, .error, .error_status);
	mtg_mem_model mem_u (.aclk, .aresetn, .ready_en, .stall, .corrupt,
		.ctrl_ready, .cmd_addr, .cmd_burst_len, .cmd_opcode, .cmd_push,
		.cmd_full, .wr_data, .wr_push, .wr_full, .rd_data, .rd_empty,
		.rd_pop);
	// ---------------------------------------------------------------
	// queue monitor
	// ---------------------------------------------------------------
	always @(posedge aclk) begin
		if (aresetn && cmd_hold) begin
			cmp({31'h0, cmd_push}, 32'h1);
			cmp(cmd_addr, cprev.addr);
			cmp({29'h0, cmd_opcode}, {29'h0, cprev.opcode});
		end
		if (aresetn && wr_hold) begin
			cmp({31'h0, wr_push}, 32'h1);
			cmp(wr_data, wprev);
		end
		if (aresetn && !ctrl_ready)
			cmp({30'h0, cmd_push, wr_push}, 32'h0);
		cmd_hold <= cmd_push && cmd_full;
		wr_hold <= wr_push && wr_full;
		cprev <= {cmd_addr, cmd_burst_len, cmd_opcode};
		wprev <= wr_data;
		if (cmd_push && !cmd_full)
			cq.push_back({cmd_addr, cmd_burst_len, cmd_opcode});
		if (wr_push && !wr_full)
			wq.push_back(wr_data);
		if (cmp_error)
			cerr_n++;
	end
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic hang();
		err_count++;
		$display("timeout at %0t", $time);
		stop_test();
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		repeat (50) begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		if (s_axi_bvalid !== 1'b1)
			hang();
		cmp({30'h0, s_axi_bresp}, 32'h0);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		repeat (50) begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		d = s_axi_rdata;
		if (s_axi_rvalid !== 1'b1)
			hang();
		cmp({30'h0, s_axi_rresp}, 32'h0);
		s_axi_rready <= 1'b0;
	endtask
	task automatic wait_idle();
		logic [31:0] s;
		int n;
		s = 32'h2;
		for (n = 0; n < 300 && s[1] !== 1'b0; n++)
			axi_rd(mtg_pkg::OFS_STATUS, s);
		if (s[1] !== 1'b0)
			hang();
	endtask
	task automatic set_mode(input logic [3:0] dm, input logic [2:0] am,
		input logic [3:0] im, input logic [2:0] op);
		axi_wr(mtg_pkg::OFS_MODE, {10'h0, 6'hf, 1'b0, op, im, 1'b0, am, dm});
	endtask
	// runs until w words went out and a command was taken, then stops
	task automatic go(input logic [31:0] c, input int w);
		int n;
		cq.delete();
		wq.delete();
		cerr_n = 0;
		axi_wr(mtg_pkg::OFS_CTRL, c);
		for (n = 0; n < 4000 && (wq.size() < w || cq.size() == 0); n++)
			@(posedge aclk);
		if (n >= 4000)
			hang();
		axi_wr(mtg_pkg::OFS_CTRL, c & 32'h2);
		wait_idle();
	endtask
	function automatic logic [31:0] exp_w(input logic [3:0] m, input int b);
		logic [31:0] one;
		logic [31:0] q;
		one = 32'h1 << ((FA[6:2] + b) % 32);
		q = 32'h1 << QUIET;
		case (m)
			mtg_pkg::DM_FIXED: return FD;
			mtg_pkg::DM_ADDR: return FA + 32'h4 * b;
			mtg_pkg::DM_HAMMER: return (b % 2 == 0) ? ~q : q;
			mtg_pkg::DM_REPEAT8: return 32'h1111_1111 * (b % 8 + 1);
			mtg_pkg::DM_WALK1: return one;
			mtg_pkg::DM_WALK0: return ~one;
			mtg_pkg::DM_PRBS: begin
				// taps 32, 22, 2, 1, seeded by the start address
				q = FA;
				for (int i = 0; i < b; i++)
					q = {q[30:0], q[31] ^ q[21] ^ q[1] ^ q[0]};
				return q;
			end
			default: return (b % 16 < 8) ? 32'hffff_ffff : 32'h0;
		endcase
	endfunction
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_no_ready();
		logic [31:0] r;
		axi_rd(mtg_pkg::OFS_MODE, r);
		cmp(r, mtg_pkg::MODE_RST);
		axi_rd(mtg_pkg::OFS_STATUS, r);
		cmp(r, 32'h0);
		axi_rd(8'h3c, r);
		cmp(r, 32'h0);
		axi_wr(mtg_pkg::OFS_FIXED_DATA, FD);
		axi_wr(mtg_pkg::OFS_FIXED_ADDR, FA);
		for (int i = 0; i < 8; i++)
			axi_wr(8'h40 + 8'(4 * i), 32'h1111_1111 * (i + 1));
		axi_wr(mtg_pkg::OFS_CTRL, 32'h3);
		repeat (40) @(posedge aclk);
		cmp(cq.size() + wq.size(), 32'h0);
		ready_en <= 1'b1;
		axi_wr(mtg_pkg::OFS_CTRL, 32'h2);
		wait_idle();
	endtask
	task automatic t_pattern(input logic [3:0] m);
		stall <= (m == mtg_pkg::DM_ADDR);
		set_mode(m, mtg_pkg::AM_FIXED, mtg_pkg::IM_FIXED, mtg_pkg::OP_WR);
		go(32'h3, 16);
		stall <= 1'b0;
		for (int b = 0; b < 16; b++)
			cmp(wq[b], exp_w(m, b));
		cmp(cq[0].addr, FA);
		cmp({26'h0, cq[0].burst_len}, 32'hf);
		cmp({29'h0, cq[0].opcode}, 32'h0);
		set_mode(m, mtg_pkg::AM_FIXED, mtg_pkg::IM_FIXED, mtg_pkg::OP_RD);
		go(32'h3, 0);
		cmp({29'h0, cq[0].opcode}, 32'h1);
		cmp({30'h0, error, rd_empty}, 32'h1);
	endtask
	task automatic t_error();
		logic [31:0] r;
		set_mode(mtg_pkg::DM_ADDR, mtg_pkg::AM_FIXED, mtg_pkg::IM_FIXED, 3'h0);
		go(32'h3, 16);
		corrupt <= 1'b1;
		set_mode(mtg_pkg::DM_ADDR, mtg_pkg::AM_FIXED, mtg_pkg::IM_FIXED, 3'h1);
		go(32'h3, 0);
		corrupt <= 1'b0;
		cmp(cerr_n, cq.size());
		cmp({31'h0, error}, 32'h1);
		cmp(error_status[31:0], FA);
		cmp({26'h0, error_status[37:32]}, 32'hf);
		cmp(error_status[95:64], FA);
		cmp(error_status[127:96], FA ^ 32'h1);
		cmp({29'h0, error_status[42:40]}, 32'h0);
		axi_wr(mtg_pkg::OFS_CTRL, 32'h4);
		axi_rd(mtg_pkg::OFS_STATUS, r);
		cmp({r[0], error}, 32'h0);
	endtask
	task automatic t_cmd_modes();
		logic [3:0] im [3];
		im = '{mtg_pkg::IM_WR0, mtg_pkg::IM_RD0, mtg_pkg::IM_FIXED};
		set_mode(mtg_pkg::DM_ADDR, mtg_pkg::AM_SEQ, mtg_pkg::IM_FIXED, 3'h0);
		go(32'h3, 32);
		cmp(cq[1].addr, cq[0].addr + 32'h4);
		for (int i = 0; i < 3; i++) begin
			set_mode(i == 2 ? mtg_pkg::DM_TRAIN : mtg_pkg::DM_ADDR,
				mtg_pkg::AM_FIXED, im[i], {2'h0, i == 0});
			go(32'h3, i == 0 ? 16 : 0);
			cmp(cq[0].addr, 32'h0);
			cmp({29'h0, cq[0].opcode}, {31'h0, i != 0});
		end
		// word 0 at address zero holds 0, so the first training read trips
		cmp(error_status[95:64], 32'hffff_ffff);
		axi_wr(mtg_pkg::OFS_CTRL, 32'h4);
	endtask
	task automatic t_override_off();
		int k;
		set_mode(mtg_pkg::DM_FIXED, mtg_pkg::AM_FIXED, mtg_pkg::IM_FIXED, 3'h0);
		go(32'h1, 16);
		k = 0;
		while (k < cq.size() - 1 && cq[k].opcode != mtg_pkg::OP_WR)
			k++;
		for (int b = 0; b < 16; b++)
			cmp(wq[b], cq[k].addr + 32'h4 * b);
		axi_wr(mtg_pkg::OFS_CTRL, 32'h4);
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_no_ready();
		for (int i = 0; i < 8; i++)
			t_pattern(DMS[i]);
		t_error();
		t_cmd_modes();
		t_override_off();
		stop_test();
	end
endmodule
